// [ssx_consts.svh]
// constants for the subtract and swap execution datapath
// How it works
// - the immediate-minus-accumulator opcode (11 110x, x ignored) writes the 8-bit difference into the accumulator.
// - the file-minus-accumulator opcode (00 0010 d fffffff) takes the addressed file register minus the accumulator.
// - for that opcode a clear destination bit sends the result to the accumulator, a set one to the file register.
// - both subtractions update carry (set when no borrow), digit carry (set when no nibble borrow) and zero.
`ifndef SSX_CONSTS_SVH
`define SSX_CONSTS_SVH
`define SSX_OP_SUBL_PAT   5'h1e
`define SSX_OP_SUBF_PAT   6'h02
`define SSX_OP_SWAP_PAT   6'h0e
`define SSX_DEST_BIT      7
`define SSX_ACC_RESET     8'h00
`define SSX_FLAG_RESET    1'b0
`endif

// [ssx_pkg.sv]
// types for the subtract and swap execution datapath
package ssx_pkg;
    typedef logic [13:0] ssx_instr_t;
    typedef logic [7:0]  ssx_byte_t;
    typedef logic [6:0]  ssx_addr_t;
endpackage

// [ssx_execute.sv]
// execution datapath: subtract from literal, subtract from file, nibble swap
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_consts.svh"
module ssx_execute (
    input  wire  logic               clock_in,
    input  wire  logic               reset_n_in,
    input  wire  logic               instr_valid_in,
    input  wire  ssx_pkg::ssx_instr_t instr_in,
    input  wire  ssx_pkg::ssx_byte_t  file_rdata_in,
    output logic                     file_we_out,
    output ssx_pkg::ssx_addr_t        file_addr_out,
    output ssx_pkg::ssx_byte_t        file_wdata_out,
    output ssx_pkg::ssx_byte_t        acc_out,
    output logic                     carry_flag_out,
    output logic                     digit_carry_flag_out,
    output logic                     zero_flag_out
);
    import ssx_pkg::*;

    // ----------------------------------------
    // overview
    // ----------------------------------------
    // one instruction is taken at every rising edge at which instr_valid_in is high;
    // its results show in the cycle after that edge, from flip-flops only.
    // the two subtractions share one 9-bit subtractor: the ninth bit of the difference is
    // the borrow, and carry is stored as its inverse, so carry set means no borrow.
    // digit carry is the same idea on the low nibble alone, with a 5-bit subtractor.
    // the nibble swap only rewires the file byte, so it leaves every flag alone.
    // file writes are registered: file_we_out, file_wdata_out and the write address all
    // stand in the cycle after the instruction, which keeps the write port glitch free.
    // trade-off: the file port has one address, so while a write is pending the address
    // points at the written register, and a file-reading instruction issued in that cycle
    // sees the pending value through a bypass when it names the same register.
    // limitation: a file-reading instruction that names another register must not be
    // issued in the write cycle; literal subtracts may follow with no gap.

    // ----------------------------------------
    // decode and arithmetic
    // ----------------------------------------
    ssx_byte_t acc_r, acc_nxt, wdata_r, wdata_nxt;
    ssx_addr_t addr_r, addr_nxt;
    logic      we_r, we_nxt, c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
    logic      is_subl, is_subf, is_swap, dest_file;
    ssx_byte_t opnd, diff;
    ssx_byte_t rdata_eff;
    logic      fwd_hit;
    logic [8:0] wide;
    logic [4:0] low;

    // operand is the literal or the file data; file port addressed combinationally
    always_comb
    begin
        is_subl   = instr_valid_in && (instr_in[13:9] == `SSX_OP_SUBL_PAT);
        is_subf   = instr_valid_in && (instr_in[13:8] == `SSX_OP_SUBF_PAT);
        is_swap   = instr_valid_in && (instr_in[13:8] == `SSX_OP_SWAP_PAT);
        dest_file = instr_in[`SSX_DEST_BIT];
        // bypass: the memory still holds the old byte while our own write is pending
        fwd_hit   = we_r && (instr_in[6:0] == addr_r);
        rdata_eff = fwd_hit ? wdata_r : file_rdata_in;
        opnd      = is_subl ? instr_in[7:0] : rdata_eff;
        // a ninth bit captures the borrow; carry is its inverse
        wide      = {1'b0, opnd} - {1'b0, acc_r};
        low       = {1'b0, opnd[3:0]} - {1'b0, acc_r[3:0]};
        diff      = wide[7:0];
    end

    // ----------------------------------------
    // file port address
    // ----------------------------------------
    // the read address follows the instruction, except in the cycle of a pending write,
    // where the memory must see the address that the write belongs to
    assign file_addr_out = we_r ? addr_r : instr_in[6:0];

    // next-state of accumulator, flags and file write
    always_comb
    begin
        acc_nxt   = acc_r;
        c_nxt     = c_r;
        dc_nxt    = dc_r;
        z_nxt     = z_r;
        we_nxt    = 1'b0;
        wdata_nxt = wdata_r;
        addr_nxt  = addr_r;
        // both subtractions load all three flags, whatever the destination
        if (is_subl || is_subf)
        begin
            c_nxt  = ~wide[8];
            dc_nxt = ~low[4];
            z_nxt  = (diff == 8'h00);
            if (is_subf && dest_file)
            begin
                we_nxt    = 1'b1;
                wdata_nxt = diff;
                addr_nxt  = instr_in[6:0];
            end
            else
            begin
                acc_nxt = diff;
            end
        end
        // the swap touches no flag, so the flag defaults above carry through
        else if (is_swap)
        begin
            if (dest_file)
            begin
                we_nxt    = 1'b1;
                wdata_nxt = {rdata_eff[3:0], rdata_eff[7:4]};
                addr_nxt  = instr_in[6:0];
            end
            else
            begin
                acc_nxt = {rdata_eff[3:0], rdata_eff[7:4]};
            end
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    // synchronous reset only; every register loads on every edge
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            acc_r   <= `SSX_ACC_RESET;
            c_r     <= `SSX_FLAG_RESET;
            dc_r    <= `SSX_FLAG_RESET;
            z_r     <= `SSX_FLAG_RESET;
            we_r    <= 1'b0;
            wdata_r <= 8'h00;
            addr_r  <= 7'h00;
        end
        else
        begin
            acc_r   <= acc_nxt;
            c_r     <= c_nxt;
            dc_r    <= dc_nxt;
            z_r     <= z_nxt;
            we_r    <= we_nxt;
            wdata_r <= wdata_nxt;
            addr_r  <= addr_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // file write is registered: write lands one cycle after the instruction
    assign file_we_out          = we_r;
    assign file_wdata_out       = wdata_r;
    assign acc_out              = acc_r;
    assign carry_flag_out       = c_r;
    assign digit_carry_flag_out = dc_r;
    assign zero_flag_out        = z_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // every check looks one edge after the instruction was taken, where the
    // registered results first stand

    // literal subtract lands in the accumulator
    a_subl_acc_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        is_subl |=> acc_out == ($past(instr_in[7:0]) - $past(acc_out)))
        else $error("literal subtract result wrong");

    // literal subtract never writes the file
    a_subl_no_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        is_subl |=> !file_we_out)
        else $error("literal subtract wrote the file");

    // file destination: write pulse, accumulator kept
    a_subf_file_dest: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_subf && dest_file) |=> file_we_out && acc_out == $past(acc_out))
        else $error("file destination subtract wrong");

    // accumulator destination: no write, difference in the accumulator
    a_subf_acc_dest: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_subf && !dest_file) |=> !file_we_out && acc_out == ($past(rdata_eff) - $past(acc_out)))
        else $error("file subtract to accumulator wrong");

    // a read of the register whose write is still pending takes the pending byte
    a_fwd_operand: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_subf && !dest_file && we_r && instr_in[6:0] == addr_r) |=> acc_out == ($past(wdata_r) - $past(acc_out)))
        else $error("pending write not forwarded");

    // the write pulse carries the address of the instruction that made it
    a_write_addr_held: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        ((is_subf || is_swap) && dest_file) |=> file_addr_out == $past(instr_in[6:0]))
        else $error("file write address wrong");

    // idle or unknown words leave the accumulator and the file alone
    a_idle_quiet: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (reset_n_in && !is_subl && !is_subf && !is_swap) |=> !file_we_out && $stable(acc_out))
        else $error("idle cycle changed state");

    // carry is the inverse of the borrow
    a_carry_no_borrow: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_subl || is_subf) |=> carry_flag_out == ($past(opnd) >= $past(acc_out)))
        else $error("carry flag wrong");

    // zero follows the stored difference
    a_zero_flag_set: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_subl || is_subf) |=> zero_flag_out == ($past(opnd) == $past(acc_out)))
        else $error("zero flag wrong");

    // the swap keeps all three flags
    a_swap_flags_kept: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        is_swap |=> $stable(carry_flag_out) && $stable(zero_flag_out) && $stable(digit_carry_flag_out))
        else $error("swap changed flags");

    // swap to the file: nibbles exchanged on the write data
    a_swap_file_data: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_swap && dest_file) |=> file_we_out && file_wdata_out == {$past(rdata_eff[3:0]), $past(rdata_eff[7:4])})
        else $error("swap data wrong");

    // swap to the accumulator: no file write
    a_swap_acc_dest: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_swap && !dest_file) |=> !file_we_out && acc_out == {$past(rdata_eff[3:0]), $past(rdata_eff[7:4])})
        else $error("swap to accumulator wrong");

    // digit carry is the inverse of the low nibble borrow
    a_dc_nibble: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (is_subl || is_subf) |=> digit_carry_flag_out == ($past(opnd[3:0]) >= $past(acc_out[3:0])))
        else $error("digit carry wrong");
endmodule // ssx_execute
`default_nettype wire

// [ssx_execute_tb.sv]
// self-checking testbench for the subtract and swap datapath
`timescale 1ns/1ps
`default_nettype none
module ssx_execute_tb;
    import ssx_pkg::*;
    logic       clock_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       valid = 1'b0;
    ssx_instr_t instr = 14'h0000;
    ssx_byte_t  rdata = 8'h00;
    logic       we, c, dc, z, ec, edc, ez;
    ssx_addr_t  addr;
    ssx_byte_t  wdata, acc, ea, res, opnd;
    int         n_mismatch = 0;
    int         n_checks = 0;
    // 250 MHz clock
    always #2 clock_in = ~clock_in;
    ssx_execute i_ssx_execute (.clock_in(clock_in), .reset_n_in(reset_n_in), .instr_valid_in(valid),
        .instr_in(instr), .file_rdata_in(rdata), .file_we_out(we), .file_addr_out(addr),
        .file_wdata_out(wdata), .acc_out(acc), .carry_flag_out(c), .digit_carry_flag_out(dc),
        .zero_flag_out(z));
    // compare one value, four-state exact
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (e !== s)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task chk_all(input logic ewe);
        chk("acc", ea, acc);
        chk("carry", ec, c);
        chk("digit_carry", edc, dc);
        chk("zero", ez, z);
        chk("file_we", ewe, we);
    endtask
    // issue one instruction with file data fv; the model is updated before the edge lands
    task op(input ssx_instr_t ins, input ssx_byte_t fv);
        logic lit, sub, swp, to_f;
        lit = ins[13:9] == 5'h1e;
        sub = lit || ins[13:8] == 6'h02;
        swp = ins[13:8] == 6'h0e;
        opnd = lit ? ins[7:0] : fv;
        res = sub ? opnd - ea : {fv[3:0], fv[7:4]};
        to_f = !lit && ins[7] && (sub || swp);
        @(posedge clock_in);
        instr <= ins;
        valid <= 1'b1;
        rdata <= fv;
        #1 chk("file_addr", {1'b0, ins[6:0]}, {1'b0, addr});
        chk("file_we", 8'h00, {7'h00, we});
        if (sub)
        begin
            ec = opnd >= ea;
            edc = opnd[3:0] >= ea[3:0];
            ez = res == 8'h00;
        end
        if ((sub || swp) && !to_f) ea = res;
        @(posedge clock_in);
        valid <= 1'b0;
        instr <= 14'h0000; // a parked word shows whether the write keeps its own address
        rdata <= ~fv; // stale read data must not leak in
        #1 chk_all(to_f);
        if (to_f) chk("file_wdata", res, wdata);
        if (to_f) chk("file_addr", {1'b0, ins[6:0]}, {1'b0, addr});
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {ea, ec, edc, ez} = 11'h000;
        repeat (12) @(posedge clock_in);
        reset_n_in <= 1'b1;
        #1 chk_all(1'b0);
        op(14'h3c02, 8'h00);
        op(14'h3d02, 8'h00);
        op(14'h3c01, 8'h00);
        op(14'h3c00, 8'h00);
        op(14'h0205, 8'h03);
        op(14'h0285, 8'h13);
        op(14'h0e7f, 8'ha5);
        op(14'h0eff, 8'h3c);
        // back to back: file write, then a read of the same register while the write is pending
        @(posedge clock_in);
        instr <= 14'h0285;
        valid <= 1'b1;
        rdata <= 8'h70;
        @(posedge clock_in);
        instr <= 14'h0205;
        rdata <= 8'h70; // memory still holds the old byte during the write pulse
        #1 chk("file_wdata", 8'h16, wdata);
        chk("file_we", 8'h01, {7'h00, we});
        chk("acc", ea, acc);
        chk("carry", 8'h01, {7'h00, c});
        @(posedge clock_in);
        valid <= 1'b0;
        {ea, ec, edc, ez} = {8'hbc, 3'b000};
        #1 chk_all(1'b0);
        op(14'h3a12, 8'h55);
        // reset again in mid-run
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        @(posedge clock_in);
        reset_n_in <= 1'b1;
        {ea, ec, edc, ez} = 11'h000;
        #1 chk_all(1'b0);
        // a matching word without valid must do nothing
        @(posedge clock_in);
        instr <= 14'h3c05;
        @(posedge clock_in);
        #1 chk_all(1'b0);
        op(14'h3c05, 8'h00);
        conclude;
    end
    // watchdog: the tests need well under 100 cycles
    initial
    begin
        repeat (400) @(posedge clock_in);
        n_mismatch++;
        conclude;
    end
endmodule // ssx_execute_tb
`default_nettype wire
